// *** hdl/ban_defs.svh ***
/*
  Constants of the battery alarm notify block: bus addresses, command codes,
  field positions and bit timing. Assumes a 40 MHz core clock.
*/
`ifndef BAN_DEFS_SVH
`define BAN_DEFS_SVH

// bus addresses, 7 bits
`define BAN_HOST_ADDR 7'h08
`define BAN_CHG_ADDR 7'h09
`define BAN_SEL_ADDR 7'h0A

// command codes of the readable words
`define BAN_CMD_CAP 8'h11
`define BAN_CMD_CHG 8'h13
`define BAN_CMD_PPS 8'h21

// capability bit that flags a built-in selector
`define BAN_CAP_SEL_BIT 4

// timing
`define BAN_CLK_HZ 40000000
`define BAN_SMB_HZ 100000
`define BAN_QTR_CYC (`BAN_CLK_HZ / (4 * `BAN_SMB_HZ))
`define BAN_QTR_LAST 8'(`BAN_QTR_CYC - 1)

`endif

// *** hdl/ban_pkg.sv ***
/*
  Types of the battery alarm notify block.
  Assumes ban_defs.svh supplies all numeric constants.
*/
`default_nettype none

package ban_pkg;

  typedef enum logic [1:0] {
    BAN_ROLE_CHARGER,
    BAN_ROLE_CHG_SEL,
    BAN_ROLE_SELECTOR
  } ban_role_t;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP} ban_mst_t;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACKW, S_CMD, S_ACKC, S_ACKR, S_TX, S_TACK
  } ban_slv_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic bus_busy;
    logic pend;
    ban_mst_t mst;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [15:0] payload;
    ban_slv_t slv;
    logic [3:0] sbit;
    logic [7:0] sshift;
    logic [7:0] scmd;
    logic [15:0] stx;
    logic sbyte;
    logic sack;
    logic scl_oe_n;
    logic sda_oe_n;
    logic drv_lvl;
    logic done;
    logic fail;
  } ban_state_t;

endpackage

`default_nettype wire

// *** hdl/ban_notify.sv ***
/*
  Battery charger / battery switch alarm notifier on the SMBus.
  Masters a notify to the host slave on each status change, except changes seen in a notify before it is NACKed, and answers
  read-word requests as a slave for the words its role allows, all three only with a built-in selector.
  Assumes open-drain pins resolved outside; status words and the change
  pulse come from logic on i_core_clk.
*/
// Notes on behaviour
// RULE1: charger-only device notifies host address 0x8 on every status change; the code drops changes seen in a notify before a NACK.
// RULE2: charger-only device sends its charger state word, command 0x13.
// RULE3: host raises its event only after data and sender address arrive.
// RULE4: capability word at command 0x11 shows built-in selector in bit 4.
// RULE5: charger with selector sends power-path state word, command 0x21.
// RULE6: with built-in selector, status changes go through power-path notify only.
// RULE7: standalone switch device notifies host 0x8 with power-path state word.
// RULE8: sender byte is the 7-bit address plus write bit.
// RULE9: host stores sender address shifted up by one bit.
// RULE10: charger answers at address 0x9 and notifies with that identity.
// RULE11: standalone switch answers at 0xA and notifies with that identity.
// RULE12: host holds address, data and event until software reads them; the host model overwrites address and data with each new notify.
`include "ban_defs.svh"
`default_nettype none

module ban_notify (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // device configuration and state
  input wire ban_pkg::ban_role_t i_role,
  input wire logic i_status_change,
  input wire logic [15:0] i_charger_state_word,
  input wire logic [15:0] i_power_path_state_word,
  input wire logic [15:0] i_charger_capability_word,
  // smbus pins
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // notify status
  output logic o_notify_busy,
  output logic o_notify_done,
  output logic o_notify_fail
);
  import ban_pkg::*;

  ban_state_t q, d;
  logic [6:0] own_addr;
  logic [15:0] cap_word;
  logic scl_rise, scl_fall, start_c, stop_c, tick, mbit, addr_hit, cmd_ok;
  logic [15:0] rd_word;
  logic [7:0] mb;

  // identity follows role
  assign own_addr = (i_role == BAN_ROLE_SELECTOR) ? `BAN_SEL_ADDR : `BAN_CHG_ADDR; // RULE10 RULE11

  always_comb begin
    cap_word = i_charger_capability_word;
    cap_word[`BAN_CAP_SEL_BIT] = (i_role == BAN_ROLE_CHG_SEL); // RULE4
  end

  // notify byte stream: host address, sender, data low, data high
  function automatic logic [7:0] mbyte(input logic [1:0] n, input logic [15:0] pl,
                                       input logic [6:0] me);
    case (n)
      2'd0: mbyte = {`BAN_HOST_ADDR, 1'b0}; // RULE1 RULE7
      2'd1: mbyte = {me, 1'b0}; // RULE8
      2'd2: mbyte = pl[7:0];
      default: mbyte = pl[15:8];
    endcase
  endfunction

  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign start_c = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_c = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  assign tick = (q.qcnt == `BAN_QTR_LAST);
  assign mb = mbyte(q.byten, q.payload, own_addr);
  assign mbit = (q.bitn < 4'd8) ? mb[3'd7 - q.bitn[2:0]] : 1'b1;
  assign addr_hit = (q.sshift[7:1] == own_addr);

  always_comb begin
    cmd_ok = 1'b0;
    rd_word = 16'h0000;
    case (q.scmd)
      `BAN_CMD_CAP: begin
        cmd_ok = (i_role != BAN_ROLE_SELECTOR);
        rd_word = cap_word;
      end
      `BAN_CMD_CHG: begin
        cmd_ok = (i_role != BAN_ROLE_SELECTOR);
        rd_word = i_charger_state_word;
      end
      `BAN_CMD_PPS: begin
        cmd_ok = (i_role != BAN_ROLE_CHARGER);
        rd_word = i_power_path_state_word;
      end
      default: begin
        cmd_ok = 1'b0;
        rd_word = 16'h0000;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.fail = 1'b0;
    d.drv_lvl = 1'b0;
    d.scl_s1 = i_scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = i_sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    if (start_c) begin
      d.bus_busy = 1'b1;
    end else if (stop_c) begin
      d.bus_busy = 1'b0;
    end
    d.pend = q.pend | i_status_change; // RULE1 RULE7

    // quarter-bit timer, held while a slave stretches the clock of a data or ack bit
    if (q.mst == M_IDLE || (q.phase == 2'd1 && !q.scl_s2 && q.mst == M_BIT)) begin
      d.qcnt = 8'h00;
    end else if (tick) begin
      d.qcnt = 8'h00;
      d.phase = q.phase + 2'd1;
    end else begin
      d.qcnt = q.qcnt + 8'h01;
    end

    case (q.mst)
      M_IDLE: begin
        if (q.pend && !q.bus_busy && q.slv == S_IDLE) begin
          d.mst = M_START;
          d.phase = 2'd0;
          d.byten = 2'd0;
          d.bitn = 4'd0;
          // changes seen from here on ask for one more notify; a NACK drops those seen before it
          d.pend = i_status_change;
          // charger-only sends charger state, others the power-path state
          d.payload = (i_role == BAN_ROLE_CHARGER) ? i_charger_state_word // RULE2
                                                   : i_power_path_state_word; // RULE5 RULE6 RULE7
        end
      end
      M_START: begin
        d.sda_oe_n = 1'b0;
        if (tick && q.phase == 2'd1) begin
          d.scl_oe_n = 1'b0;
          d.mst = M_BIT;
          d.phase = 2'd0;
        end
      end
      M_BIT: begin
        if (q.phase == 2'd0) begin
          d.scl_oe_n = 1'b0;
          d.sda_oe_n = mbit;
        end else if (q.phase == 2'd3) begin
          d.scl_oe_n = 1'b0;
        end else begin
          d.scl_oe_n = 1'b1;
        end
        if (tick && q.phase == 2'd2) begin
          if (q.bitn == 4'd8 && q.sda_s2) begin
            d.mst = M_STOP;
            d.phase = 2'd0;
            d.fail = 1'b1;
            d.pend = i_status_change;
          end else if (q.bitn < 4'd8 && mbit && !q.sda_s2) begin
            // lost arbitration: let go and retry when the bus is free
            d.mst = M_IDLE;
            d.pend = 1'b1;
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
          end
        end
        if (tick && q.phase == 2'd3) begin
          if (q.bitn == 4'd8) begin
            d.bitn = 4'd0;
            d.byten = q.byten + 2'd1;
            if (q.byten == 2'd3) begin
              d.mst = M_STOP;
            end
          end else begin
            d.bitn = q.bitn + 4'd1;
          end
        end
      end
      M_STOP: begin
        if (q.phase == 2'd0) begin
          d.scl_oe_n = 1'b0;
          d.sda_oe_n = 1'b0;
        end else if (q.phase == 2'd1) begin
          d.scl_oe_n = 1'b1;
        end else begin
          d.sda_oe_n = 1'b1;
        end
        if (tick && q.phase == 2'd3) begin
          d.mst = M_IDLE;
          if (!q.fail && q.byten == 2'd0 && q.bitn == 4'd0) begin
            d.done = 1'b1;
          end
        end
      end
      default: d.mst = M_IDLE;
    endcase

    // slave side: read-word and command writes to own address
    if (q.mst == M_IDLE && d.mst == M_IDLE) begin
      if (start_c) begin
        d.slv = S_ADDR;
        d.sbit = 4'd0;
        d.sda_oe_n = 1'b1;
      end else if (stop_c) begin
        d.slv = S_IDLE;
        d.sda_oe_n = 1'b1;
      end else begin
        if (scl_rise && q.sbit < 4'd8 && (q.slv == S_ADDR || q.slv == S_CMD || q.slv == S_TX)) begin
          d.sshift = {q.sshift[6:0], q.sda_s2};
          d.sbit = q.sbit + 4'd1;
        end
        case (q.slv)
          S_IDLE: d.sda_oe_n = 1'b1;
          S_ADDR: begin
            if (scl_fall && q.sbit == 4'd8) begin
              if (addr_hit && !q.sshift[0]) begin
                d.slv = S_ACKW;
                d.sda_oe_n = 1'b0;
              end else if (addr_hit && cmd_ok) begin
                d.slv = S_ACKR;
                d.sda_oe_n = 1'b0;
              end else begin
                d.slv = S_IDLE;
              end
            end
          end
          S_ACKW: begin
            if (scl_fall) begin
              d.sda_oe_n = 1'b1;
              d.slv = S_CMD;
              d.sbit = 4'd0;
            end
          end
          S_CMD: begin
            if (scl_fall && q.sbit == 4'd8) begin
              d.scmd = q.sshift;
              d.sda_oe_n = 1'b0;
              d.slv = S_ACKC;
            end
          end
          S_ACKC: begin
            if (scl_fall) begin
              d.sda_oe_n = 1'b1;
              d.slv = S_IDLE;
            end
          end
          S_ACKR: begin
            if (scl_fall) begin
              d.stx = {rd_word[7:0], rd_word[15:8]};
              d.sda_oe_n = rd_word[7];
              d.sbit = 4'd0;
              d.sbyte = 1'b0;
              d.slv = S_TX;
            end
          end
          S_TX: begin
            if (scl_fall && q.sbit != 4'd0) begin
              d.stx = {q.stx[14:0], 1'b0};
              if (q.sbit == 4'd8) begin
                d.sda_oe_n = 1'b1;
                d.slv = S_TACK;
              end else begin
                d.sda_oe_n = q.stx[14];
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              d.sack = ~q.sda_s2;
            end
            if (scl_fall) begin
              if (q.sack && !q.sbyte) begin
                d.sbyte = 1'b1;
                d.sbit = 4'd0;
                d.sda_oe_n = q.stx[15];
                d.slv = S_TX;
              end else begin
                d.slv = S_IDLE;
              end
            end
          end
          default: d.slv = S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_p <= 1'b1;
      q.mst <= M_IDLE;
      q.slv <= S_IDLE;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_scl_o = q.drv_lvl;
  assign o_sda_o = q.drv_lvl;
  assign o_scl_oe_n = q.scl_oe_n;
  assign o_sda_oe_n = q.sda_oe_n;
  assign o_notify_busy = (q.mst != M_IDLE);
  assign o_notify_done = q.done;
  assign o_notify_fail = q.fail;

endmodule

`default_nettype wire

// *** sim/ban_notify_sva.sv ***
/*
  Checker of the notify pins and status pulses of ban_notify.
  Assumes i_scl and i_sda carry the resolved, pulled-up bus levels.
*/
`include "ban_defs.svh"
`default_nettype none
module ban_notify_sva (
  input wire logic i_core_clk, i_nrst,
  input wire ban_pkg::ban_role_t i_role,
  input wire logic i_status_change,
  input wire logic [15:0] i_charger_state_word, i_power_path_state_word,
  input wire logic [15:0] i_charger_capability_word,
  input wire logic i_scl, o_scl_o, o_scl_oe_n, i_sda, o_sda_o, o_sda_oe_n,
  input wire logic o_notify_busy, o_notify_done, o_notify_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  import ban_pkg::*;
  logic scl_q;
  // every sda level at a rising scl of a notify, stop bit last
  logic [36:0] sh_q;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sh_q <= '0;
    end else begin
      scl_q <= i_scl;
      if (i_scl && !scl_q && o_notify_busy) sh_q <= {sh_q[35:0], i_sda};
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_host_addr;
    o_notify_done |-> sh_q[36:28] == {`BAN_HOST_ADDR, 2'b00};
  endproperty
  a_host_addr: assert property (p_host_addr) else $error("bad host byte");
  property p_sender;
    o_notify_done |-> sh_q[27:19] ==
      {(i_role == BAN_ROLE_SELECTOR) ? `BAN_SEL_ADDR : `BAN_CHG_ADDR, 2'b00};
  endproperty
  a_sender: assert property (p_sender) else $error("bad sender byte");
  property p_chg_word;
    o_notify_done && i_role == BAN_ROLE_CHARGER |-> {sh_q[9:2], sh_q[18:11]} ==
      i_charger_state_word;
  endproperty
  a_chg_word: assert property (p_chg_word) else $error("bad charger word");
  property p_pps_word;
    o_notify_done && i_role != BAN_ROLE_CHARGER |-> {sh_q[9:2], sh_q[18:11]} ==
      i_power_path_state_word;
  endproperty
  a_pps_word: assert property (p_pps_word) else $error("bad power word");
  property p_kick;
    i_status_change && !o_notify_busy && i_scl && i_sda |-> ##[1:8] o_notify_busy;
  endproperty
  a_kick: assert property (p_kick) else $error("notify not started");
  property p_start;
    $rose(o_notify_busy) |-> ##[0:4] (!o_sda_oe_n && o_scl_oe_n);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_end;
    o_notify_done || o_notify_fail |->
      !(o_notify_done && o_notify_fail) && $past(o_notify_busy) && o_scl_oe_n && o_sda_oe_n;
  endproperty
  a_end: assert property (p_end) else $error("bad notify end");
  property p_od;
    o_notify_busy |-> !o_scl_o && !o_sda_o;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_acked;
    o_notify_done |-> !sh_q[10] && !sh_q[1];
  endproperty
  a_acked: assert property (p_acked) else $error("done without ack");
endmodule
bind ban_notify ban_notify_sva i_sva (.*);
`default_nettype wire

// *** sim/ban_host_model.sv ***
/*
  Behavioural host slave that takes alarm notifies and raises an event.
  Assumes resolved, pulled-up bus levels on i_scl and i_sda.
*/
`include "ban_defs.svh"
`default_nettype none
module ban_host_model (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack_low,
  input wire logic i_evt_clr,
  output logic o_sda_oe_n,
  output logic [7:0] o_cmd,
  output logic [15:0] o_data,
  output logic o_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b [4];
  int k;
  initial begin
    o_sda_oe_n = 1'b1;
    o_evt = 1'b0;
    forever begin
      @(negedge i_sda iff i_scl === 1'b1);
      for (k = 0; k < 4; k++) begin
        repeat (8) @(posedge i_scl) b[k] = {b[k][6:0], i_sda};
        @(negedge i_scl);
        if ((k == 0 && b[0] != {`BAN_HOST_ADDR, 1'b0}) || (k == 2 && i_nack_low)) break;
        o_sda_oe_n = 1'b0;
        @(negedge i_scl);
        o_sda_oe_n = 1'b1;
      end
      if (k == 4) begin
        o_cmd = b[1];
        o_data = {b[3], b[2]};
        o_evt = 1'b1;
      end
    end
  end
  // event stays until software clears it
  always @(posedge i_evt_clr) o_evt = 1'b0;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench of ban_notify against a host slave model.
  Assumes a 40 MHz core clock and pull-ups on both bus lines.
*/
`include "ban_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ban_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, chg = 1'b0, nack = 1'b0, clr = 1'b0;
  ban_role_t role = BAN_ROLE_CHARGER;
  logic [15:0] cw = '0, pw = '0, capw = '0, data;
  logic scl_oe_n, sda_oe_n, scl_o, sda_o, h_oe_n, busy, done, fail, evt;
  logic [7:0] cmd;
  logic [31:0] seed = 32'h0000_002D;
  wire logic scl = scl_oe_n ? 1'b1 : scl_o;
  wire logic sda = (sda_oe_n ? 1'b1 : sda_o) & h_oe_n;
  int mismatches = 0, total_checks = 0, cyc = 0, ndone = 0, nfail = 0;
  ban_notify i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_role(role), .i_status_change(chg),
    .i_charger_state_word(cw), .i_power_path_state_word(pw),
    .i_charger_capability_word(capw), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .o_notify_busy(busy),
    .o_notify_done(done), .o_notify_fail(fail));
  ban_host_model i_host (.i_scl(scl), .i_sda(sda), .i_nack_low(nack), .i_evt_clr(clr),
    .o_sda_oe_n(h_oe_n), .o_cmd(cmd), .o_data(data), .o_evt(evt));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] exp_snd(input ban_role_t r);
    return {(r == BAN_ROLE_SELECTOR) ? `BAN_SEL_ADDR : `BAN_CHG_ADDR, 1'b0};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse;
    @(negedge clk) chg = 1'b1;
    @(negedge clk) chg = 1'b0;
  endtask
  // one change pulse, or two when n > 1, the second one while the first notify runs
  task automatic send(input ban_role_t r, input logic nk, input int n);
    int d0, f0, t;
    d0 = ndone;
    f0 = nfail;
    t = 0;
    repeat (20) @(negedge clk);
    role = r;
    nack = nk;
    seed = xs(seed);
    cw = seed[15:0];
    pw = seed[31:16];
    capw = seed[23:8];
    pulse();
    while (n > 1 && busy !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (n > 1) pulse();
    while (ndone + nfail < d0 + f0 + n && t < 40000) begin
      @(negedge clk);
      t++;
    end
    chk("done count", 16'(nk ? 0 : n), 16'(ndone - d0));
    chk("fail count", 16'(nk), 16'(nfail - f0));
    chk("event", {15'h0000, !nk}, {15'h0000, evt});
    if (!nk) chk("sender", {8'h00, exp_snd(r)}, {8'h00, cmd});
    if (!nk) chk("payload", (r == BAN_ROLE_CHARGER) ? cw : pw, data);
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
  endtask
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (done === 1'b1) ndone++;
    if (fail === 1'b1) nfail++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    send(BAN_ROLE_CHARGER, 1'b0, 1);
    send(BAN_ROLE_CHG_SEL, 1'b0, 1);
    send(BAN_ROLE_SELECTOR, 1'b0, 2);
    send(BAN_ROLE_CHARGER, 1'b1, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
